// *** verilog/disc_seq_pkg.sv ***
package disc_seq_pkg;

   // Clock period and the printed times, all in nanoseconds.
   localparam int CLK_PERIOD_NS = 8;
   localparam int COMPARE_WIN_NS = 4000;
   localparam int SIP_MIN_NS = 1200;
   localparam int ADDR_STABLE_NS = 1000;
   localparam int ADDR_TIMING_NS = 1000;
   localparam int INDEX_MIN_NS = 2000;

   // Cycle counts, least times rounded up to whole cycles.
   localparam logic [8:0] COMPARE_WIN_CYC =
      9'((COMPARE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] SIP_MIN_CYC =
      8'((SIP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [6:0] ADDR_STABLE_CYC =
      7'((ADDR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0] ACCEPT_END_CYC =
      9'(2 * ((ADDR_TIMING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS));
   localparam logic [8:0] INDEX_MIN_CYC =
      9'((INDEX_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Field widths.
   localparam int SECTOR_W = 6;
   localparam int BAND_W = 9;
   localparam int CHAR_W = 7;

   // Leading gap length and the gap clock that opens the read inputs.
   localparam int GAP_COUNTS = 13;
   localparam int READ_EN_COUNT = 3;
   localparam logic [6:0] GAP_END_CHR = 7'((GAP_COUNTS - 1) / 3);
   localparam logic [1:0] GAP_END_MOD = 2'((GAP_COUNTS - 1) % 3);
   localparam logic [6:0] RDEN_CHR = 7'((READ_EN_COUNT - 1) / 3);
   localparam logic [1:0] RDEN_MOD = 2'((READ_EN_COUNT - 1) % 3);
   localparam logic [1:0] MOD3_ZERO = 2'h0;
   localparam logic [1:0] MOD3_ONE = 2'h1;
   localparam logic [1:0] MOD3_TWO = 2'h2;
   localparam logic [5:0] CHR_UPPER_ONES = 6'h3F;

   // Register byte offsets.
   localparam logic [3:0] REG_ADDRESS = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_BAND = 4'h8;

   // Address register layout.
   localparam int ADDR_SECTOR_LSB = 0;
   localparam int ADDR_BAND_LSB = 6;

   // Status register layout.
   localparam int ST_PHASE_LSB = 0;
   localparam int ST_MATCH = 2;
   localparam int ST_RDEN = 3;
   localparam int ST_CONN = 4;
   localparam int ST_ERR = 5;
   localparam int ST_ACCEPT = 6;
   localparam int ST_LOADED = 7;
   localparam int ST_FOUND = 8;
   localparam int ST_PREAMBLE = 9;
   localparam int ST_DATA = 10;
   localparam int ST_SECTOR_LSB = 12;
   localparam int ST_MOD3_LSB = 18;
   localparam int ST_CHR_LSB = 20;

   // Phase codes as seen on the two phase bits.
   localparam logic [1:0] PHASE_STANDBY = 2'h0;
   localparam logic [1:0] PHASE_WRITE = 2'h1;
   localparam logic [1:0] PHASE_READ = 2'h2;

   // Reset values.
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef enum logic [2:0]
   {
      ST_STANDBY = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ = 3'b100
   } phase_e;

   typedef struct packed
   {
      logic [1:0] mod3;
      logic [CHAR_W-1:0] chr;
   } seqCount_s;

endpackage : disc_seq_pkg

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; the level moves only when stages two and three
// agree, which also rejects a single-cycle glitch.
module pin_sync
(
   input logic clock,
   input logic sys_rst,
   input logic clockEn,
   input logic pinIn,
   output logic levelOut
);

   logic [2:0] stage;

   // The first stage feeds only the second one.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         stage <= 3'h0;
         levelOut <= 1'b0;
      end
      else if (clockEn)
      begin
         stage <= {stage[1:0], pinIn};
         if (stage[1] == stage[2])
            levelOut <= stage[2];
      end
   end

endmodule : pin_sync

// *** verilog/disc_sector_search_gap_seq.sv ***
`timescale 1ns/1ps
// Functional notes
// R1: Two-bit phase: 00 standby or gap, 01 write, 10 read; reset to standby.
// R2: Standby and write use the prerecorded write clock track as clock.
// R3: Sector track pulses are split into sector pulses and one index pulse.
// R4: Band address is copied at each sector pulse, fixing head selection.
// R5: Six-bit sector position counts sector pulses, cleared by index pulse.
// R6: In standby with address loaded and accepted, next sector opens window.
// R7: Sector pulse lasts the minimum; address stable 1 usec before window.
// R8: Window waits for accept flag clear, which ends after second pulse.
// R9: Sector position equal to address sector in window sets search match.
// R10: Match while unconnected raises a sector found signal for interrupts.
// R11: Modulo-3 counter feeds a seven-bit character counter once per cycle.
// R12: Counters step on gated clock: active phases, or match in standby.
// R13: Counters clear in standby whenever search match is clear.
// R14: Decoded modulo-3 count 0 and count 2 are provided as outputs.
// R15: Last two character counts decoded when upper six stages are set.
// R16: Leading gap after match lasts thirteen clock pulses.
// R17: Third gap clock sets the read enable flag.
// R18: Connect command with device address sets connected, clears error.
// R19: Thirteenth gap count clears search match, ending the gap.
// R20: Gap end, connected and addressed: direction picks write or read.
// R21: A write clears read enable while leaving standby.
// R22: Address lines dropped outside gap or preamble clear connected.
// R23: Gap end initialises the preamble and data flags for the next phase.
module disc_sector_search_gap_seq
   import disc_seq_pkg::*;
(
   input logic clock,
   input logic clockEn,
   input logic sys_rst,
   input logic [3:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input logic sectorTrackIn,
   input logic writeClockTrackIn,
   input logic readDataClockIn,
   input logic buffer_connect_command,
   input logic cmdAddrMatch,
   input logic device_address_match,
   input logic transfer_direction_bit,
   input logic preambleDone,
   input logic phaseEnd,
   output logic phase_bit_high,
   output logic phase_bit_low,
   output logic search_match_flag,
   output logic read_enable_flag,
   output logic channel_connected_flag,
   output logic error_flag,
   output logic sectorFoundIrq,
   output logic sector_increment_pulse,
   output logic sector_or_index_pulse,
   output logic gap_end_ready,
   output logic count0Decode,
   output logic count2Decode,
   output logic last_counts_decode,
   output logic [BAND_W-1:0] bandLatched,
   output logic [SECTOR_W-1:0] sectorPosition
);

   phase_e state;
   seqCount_s cnt;
   logic secTrk, wclk, rclk, secPrev, wclkPrev, rclkPrev;
   logic [8:0] widthCnt, winCnt, acceptCnt;
   logic [7:0] sipCnt;
   logic [6:0] stableCnt;
   logic secEvt, idxEvt, clkPulse, standby, inGap, gapStep, gapEnd;
   logic window, acceptFlag, addrLoaded, preambleFlag, dataFlag;
   logic compareWindowOneshot, connectReq, addrWr, badWr, sipEnd, match;
   logic [SECTOR_W-1:0] addrSector;
   logic [BAND_W-1:0] addrBand;

   pin_sync secSync (.clock(clock), .sys_rst(sys_rst), .clockEn(clockEn),
      .pinIn(sectorTrackIn), .levelOut(secTrk));
   pin_sync wclkSync (.clock(clock), .sys_rst(sys_rst), .clockEn(clockEn),
      .pinIn(writeClockTrackIn), .levelOut(wclk));
   pin_sync rclkSync (.clock(clock), .sys_rst(sys_rst), .clockEn(clockEn),
      .pinIn(readDataClockIn), .levelOut(rclk));

   // Edge history of the synchronised pins.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         secPrev <= 1'b0;
         wclkPrev <= 1'b0;
         rclkPrev <= 1'b0;
      end
      else if (clockEn)
      begin
         secPrev <= secTrk;
         wclkPrev <= wclk;
         rclkPrev <= rclk;
      end
   end

   // Read phase runs on the data clock; elsewhere the track clock rules.
   assign clkPulse = (state == ST_READ) ? (rclk & ~rclkPrev) :
      (wclk & ~wclkPrev); // R2
   assign standby = (state == ST_STANDBY);
   assign inGap = standby & search_match_flag;
   assign gapStep = inGap & clkPulse; // R12
   assign gapEnd = gapStep & (cnt.chr == GAP_END_CHR) &
      (cnt.mod3 == GAP_END_MOD); // R16
   assign addrWr = avs_write & ~avs_waitrequest &
      (avs_address == REG_ADDRESS);
   assign badWr = addrWr & ~(standby & ~channel_connected_flag);
   assign connectReq = standby & buffer_connect_command & cmdAddrMatch;
   assign sipEnd = (sipCnt == 8'h01);
   assign match = window & (sectorPosition == addrSector);

   // Pulse width tells the long index mark from an ordinary sector mark.
   // A pulse is classed only at its trailing edge, so every sector event
   // comes one pulse width late; the position count does not care.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         widthCnt <= 9'h000;
      else if (clockEn)
      begin
         if (!secTrk)
            widthCnt <= 9'h000;
         else if (widthCnt != INDEX_MIN_CYC)
            widthCnt <= widthCnt + 9'h001;
      end
   end
   assign secEvt = ~secTrk & secPrev & (widthCnt != INDEX_MIN_CYC); // R3
   assign idxEvt = ~secTrk & secPrev & (widthCnt == INDEX_MIN_CYC); // R3

   // Sector position, band copy and the stretched increment pulse.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         sectorPosition <= 6'h00;
         bandLatched <= 9'h000;
         sipCnt <= 8'h00;
         sector_increment_pulse <= 1'b0;
         sector_or_index_pulse <= 1'b0;
      end
      else if (clockEn)
      begin
         sector_or_index_pulse <= secEvt | idxEvt;
         if (idxEvt)
            sectorPosition <= 6'h00; // R5
         else if (secEvt)
            sectorPosition <= sectorPosition + 6'h01; // R5
         if (secEvt)
            bandLatched <= addrBand; // R4
         if (secEvt)
            sipCnt <= SIP_MIN_CYC; // R7
         else if (sipCnt != 8'h00)
            sipCnt <= sipCnt - 8'h01;
         sector_increment_pulse <= secEvt | (sipCnt > 8'h01);
      end
   end

   // Address register and its write handshake; the accept flag falls
   // after two timing pulses so the search never sees a moving address.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         addrSector <= 6'h00;
         addrBand <= 9'h000;
         acceptFlag <= 1'b0;
         acceptCnt <= 9'h000;
         stableCnt <= 7'h00;
      end
      else if (clockEn)
      begin
         if (addrWr && !badWr)
         begin
            addrSector <= avs_writedata[ADDR_SECTOR_LSB +: SECTOR_W];
            addrBand <= avs_writedata[ADDR_BAND_LSB +: BAND_W];
            acceptFlag <= 1'b1;
            acceptCnt <= 9'h000;
            stableCnt <= ADDR_STABLE_CYC; // R7
         end
         else
         begin
            if (acceptFlag)
               acceptCnt <= acceptCnt + 9'h001;
            if (acceptFlag && acceptCnt == ACCEPT_END_CYC - 9'h001)
               acceptFlag <= 1'b0; // R8
            if (stableCnt != 7'h00)
               stableCnt <= stableCnt - 7'h01;
         end
      end
   end

   // Compare window opens as the increment pulse ends, once the
   // position counter has settled.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         winCnt <= 9'h000;
         window <= 1'b0;
      end
      else if (clockEn)
      begin
         if (standby && addrLoaded && !acceptFlag && stableCnt == 7'h00
            && sipEnd && !search_match_flag) // R6 R8
         begin
            winCnt <= COMPARE_WIN_CYC;
            window <= 1'b1;
         end
         else if (winCnt > 9'h001)
            winCnt <= winCnt - 9'h001;
         else
         begin
            winCnt <= 9'h000;
            window <= 1'b0;
         end
      end
   end
   assign compareWindowOneshot = window;

   // Search match and the gap flags; the set side wins every tie.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         search_match_flag <= 1'b0;
         read_enable_flag <= 1'b0;
         addrLoaded <= 1'b0;
         preambleFlag <= 1'b0;
         dataFlag <= 1'b0;
         sectorFoundIrq <= 1'b0;
      end
      else if (clockEn)
      begin
         if (standby && compareWindowOneshot && match)
            search_match_flag <= 1'b1; // R9
         else if (gapEnd)
            search_match_flag <= 1'b0; // R19
         if (standby && match && !channel_connected_flag)
            sectorFoundIrq <= 1'b1; // R10
         else if (channel_connected_flag || gapEnd)
            sectorFoundIrq <= 1'b0;
         if (gapStep && cnt.chr == RDEN_CHR && cnt.mod3 == RDEN_MOD)
            read_enable_flag <= 1'b1; // R17
         else if (gapEnd && channel_connected_flag && device_address_match
            && transfer_direction_bit)
            read_enable_flag <= 1'b0; // R21
         else if (!standby && phaseEnd)
            read_enable_flag <= 1'b0;
         if (addrWr && !badWr)
            addrLoaded <= 1'b1;
         else if (!standby && phaseEnd)
            addrLoaded <= 1'b0;
         if (gapEnd && channel_connected_flag && device_address_match)
         begin
            preambleFlag <= 1'b1; // R23
            dataFlag <= 1'b0; // R23
         end
         else if (preambleDone && !standby)
         begin
            preambleFlag <= 1'b0;
            dataFlag <= 1'b1;
         end
         else if (phaseEnd)
         begin
            preambleFlag <= 1'b0;
            dataFlag <= 1'b0;
         end
      end
   end

   // Connection to the channel and the error flag.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         channel_connected_flag <= 1'b0;
         error_flag <= 1'b0;
      end
      else if (clockEn)
      begin
         if (connectReq)
            channel_connected_flag <= 1'b1; // R18
         else if (clkPulse && !device_address_match && !inGap
            && !preambleFlag)
            channel_connected_flag <= 1'b0; // R22
         if (badWr)
            error_flag <= 1'b1;
         else if (connectReq)
            error_flag <= 1'b0; // R18
      end
   end

   // Phase sequencer; leaving the active phases is the data logic's call.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         state <= ST_STANDBY; // R1
      else if (clockEn)
      begin
         case (state)
            ST_STANDBY:
               if (gapEnd && channel_connected_flag && device_address_match)
                  state <= transfer_direction_bit ? ST_WRITE : ST_READ; // R20
            ST_WRITE, ST_READ:
               if (phaseEnd)
                  state <= ST_STANDBY;
            default:
               state <= ST_STANDBY;
         endcase
      end
   end

   // Modulo-3 stage feeding the character counter.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         cnt <= '0;
      else if (clockEn)
      begin
         if (standby && !search_match_flag)
            cnt <= '0; // R13
         else if (clkPulse)
         begin
            case (cnt.mod3) // R11
               MOD3_ZERO: cnt.mod3 <= MOD3_ONE;
               MOD3_ONE: cnt.mod3 <= MOD3_TWO;
               default: cnt.mod3 <= MOD3_ZERO;
            endcase
            if (cnt.mod3 == MOD3_TWO)
               cnt.chr <= cnt.chr + 7'h01; // R11
         end
      end
   end

   // Registered decodes and phase bits, one cycle behind their sources.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         count0Decode <= 1'b1;
         count2Decode <= 1'b0;
         last_counts_decode <= 1'b0;
         gap_end_ready <= 1'b0;
         phase_bit_high <= 1'b0;
         phase_bit_low <= 1'b0;
      end
      else if (clockEn)
      begin
         count0Decode <= (cnt.mod3 == MOD3_ZERO); // R14
         count2Decode <= cnt.mod3[1]; // R14
         last_counts_decode <= (cnt.chr[6:1] == CHR_UPPER_ONES); // R15
         gap_end_ready <= gapEnd & channel_connected_flag;
         phase_bit_high <= (state == ST_READ); // R1
         phase_bit_low <= (state == ST_WRITE); // R1
      end
   end

   // Avalon slave: one wait cycle, then a single acknowledge cycle.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= WORD_ZERO;
      end
      else if (clockEn)
      begin
         if ((avs_read || avs_write) && avs_waitrequest)
         begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= WORD_ZERO;
            if (avs_read)
            begin
               case (avs_address)
                  REG_ADDRESS:
                  begin
                     avs_readdata[ADDR_SECTOR_LSB +: SECTOR_W] <= addrSector;
                     avs_readdata[ADDR_BAND_LSB +: BAND_W] <= addrBand;
                  end
                  REG_STATUS:
                  begin
                     avs_readdata[ST_PHASE_LSB +: 2] <=
                        {phase_bit_high, phase_bit_low};
                     avs_readdata[ST_MATCH] <= search_match_flag;
                     avs_readdata[ST_RDEN] <= read_enable_flag;
                     avs_readdata[ST_CONN] <= channel_connected_flag;
                     avs_readdata[ST_ERR] <= error_flag;
                     avs_readdata[ST_ACCEPT] <= acceptFlag;
                     avs_readdata[ST_LOADED] <= addrLoaded;
                     avs_readdata[ST_FOUND] <= sectorFoundIrq;
                     avs_readdata[ST_PREAMBLE] <= preambleFlag;
                     avs_readdata[ST_DATA] <= dataFlag;
                     avs_readdata[ST_SECTOR_LSB +: SECTOR_W] <= sectorPosition;
                     avs_readdata[ST_MOD3_LSB +: 2] <= cnt.mod3;
                     avs_readdata[ST_CHR_LSB +: CHAR_W] <= cnt.chr;
                  end
                  REG_BAND:
                     avs_readdata[BAND_W-1:0] <= bandLatched;
                  default:
                     avs_readdata <= WORD_ZERO;
               endcase
            end
         end
         else
            avs_waitrequest <= 1'b1;
      end
   end

   // Checks on the sequencing.
   logic [7:0] sipLen;
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         sipLen <= 8'h00;
      else if (clockEn)
         sipLen <= sector_increment_pulse ? sipLen + 8'h01 : 8'h00;
   end

   sequence gapWriteSeq;
      gapEnd && channel_connected_flag && device_address_match &&
         transfer_direction_bit && clockEn;
   endsequence

   sequence connectSeq;
      connectReq && !badWr && clockEn;
   endsequence

   a_phase_code_legal: assert property (@(posedge clock) disable iff (sys_rst)
      !(phase_bit_high && phase_bit_low)) // R1
      else $error("Illegal phase code.");
   a_counter_clear: assert property (@(posedge clock) disable iff (sys_rst)
      standby && !search_match_flag && clockEn |=> cnt == '0) // R13
      else $error("Counters not cleared.");
   a_gap_end_clear: assert property (@(posedge clock) disable iff (sys_rst)
      gapEnd && clockEn |=> !search_match_flag) // R19
      else $error("Search match survived gap end.");
   a_window_after_accept: assert property (@(posedge clock)
      disable iff (sys_rst) $rose(window) |-> !$past(acceptFlag)) // R8
      else $error("Window opened during accept.");
   a_sip_min_width: assert property (@(posedge clock) disable iff (sys_rst)
      $fell(sector_increment_pulse) |-> sipLen >= SIP_MIN_CYC) // R7
      else $error("Sector pulse too short.");
   a_match_cause: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(search_match_flag) |-> $past(window && match)) // R9
      else $error("Match without equal sector.");
   a_read_enable_third: assert property (@(posedge clock)
      disable iff (sys_rst) $rose(read_enable_flag) |->
      $past(gapStep && cnt.mod3 == RDEN_MOD && cnt.chr == RDEN_CHR)) // R17
      else $error("Read enable off the third clock.");
   a_connect_effect: assert property (@(posedge clock) disable iff (sys_rst)
      connectSeq |=> channel_connected_flag && !error_flag) // R18
      else $error("Connect did not take.");
   a_gap_to_write: assert property (@(posedge clock) disable iff (sys_rst)
      gapWriteSeq |=> state == ST_WRITE && !read_enable_flag) // R20
      else $error("Write phase not entered.");
   a_disconnect: assert property (@(posedge clock) disable iff (sys_rst)
      clkPulse && clockEn && !device_address_match && !inGap &&
      !preambleFlag && !connectReq |=> !channel_connected_flag) // R22
      else $error("Connected flag not dropped.");

endmodule : disc_sector_search_gap_seq

// *** testbench/disc_track_model.sv ***
`timescale 1ns/1ps
// Disc surface model: the prerecorded clock track and the clock that the
// read amplifiers recover from data, both at the nominal bit period.
module disc_track_model
#(
   parameter int PERIOD = 150,
   parameter int HIGH = 62
)
(
   input wire logic clock,
   output logic writeClockTrackIn,
   output logic readDataClockIn
);
   int phaseCnt = 0;

   // The track is recorded all round the disc, so it never stops.
   always @(posedge clock)
   begin
      phaseCnt <= (phaseCnt == PERIOD - 1) ? 0 : phaseCnt + 1;
   end

   // Half a period apart, so the read clock rises midway between track clock rises.
   assign writeClockTrackIn = (phaseCnt < HIGH);
   assign readDataClockIn = (phaseCnt >= 75) && (phaseCnt < 75 + HIGH);
endmodule : disc_track_model

// *** testbench/disc_sector_search_gap_seq_tb.sv ***
`timescale 1ns/1ps
// Bench for the sector search and leading gap sequencer.
module disc_sector_search_gap_seq_tb;
   import disc_seq_pkg::*;
   logic clock = 0, clockEn = 1, sys_rst = 1, avs_read = 0, avs_write = 0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic avs_waitrequest, sectorTrackIn = 0, wPrev = 0;
   logic writeClockTrackIn, readDataClockIn, buffer_connect_command = 0;
   logic cmdAddrMatch = 0, device_address_match = 0;
   logic transfer_direction_bit = 0, preambleDone = 0, phaseEnd = 0;
   logic phase_bit_high, phase_bit_low, search_match_flag, read_enable_flag;
   logic channel_connected_flag, error_flag, sectorFoundIrq;
   logic sector_increment_pulse, sector_or_index_pulse, gap_end_ready;
   logic count0Decode, count2Decode, last_counts_decode;
   logic [BAND_W-1:0] bandLatched;
   logic [SECTOR_W-1:0] sectorPosition;
   int n_errors = 0;
   int total_checks = 0;

   disc_sector_search_gap_seq i_dut (.*);
   disc_track_model i_disc (.*);

   // Free-running clock and a one-cycle copy of the track for edges.
   initial
   begin
      forever #4 clock = ~clock;
   end
   always @(posedge clock) wPrev <= writeClockTrackIn;

   task automatic results;
      if (n_errors == 0 && total_checks > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   task automatic hang;
      n_errors++;
      results();
   endtask : hang

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
         n_errors++;
      end
   endtask : check

   // One bus word; the request stands until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clock);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      if (k == 50) hang();
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   // A track pulse starts just after a clock bit, so that later events
   // keep well clear of the synchroniser's uncertain cycle.
   task automatic track(input int len);
      int k;
      for (k = 0; k < 400; k++)
      begin
         @(posedge clock);
         if (writeClockTrackIn === 1'b1 && wPrev === 1'b0) break;
      end
      if (k == 400) hang();
      sectorTrackIn <= 1'b1;
      repeat (len) @(posedge clock);
      sectorTrackIn <= 1'b0;
   endtask : track

   task automatic regAccess;
      check("count0", 32'h1, count0Decode);
      check("phase", 32'h0, {phase_bit_high, phase_bit_low});
      bus(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
      bus(1'b0, 4'hC, 32'h0, rd);
      check("unmapped", 32'h0, rd);
      bus(1'b1, REG_ADDRESS, 32'h0000_5542, rd);
      // A frozen enable must keep the accept flag up past its own count.
      clockEn <= 1'b0;
      repeat (300) @(posedge clock);
      clockEn <= 1'b1;
      bus(1'b0, REG_STATUS, 32'h0, rd);
      check("accept", 32'h1, rd[ST_ACCEPT]);
   endtask : regAccess

   // Search for sector 2, count the gap, then leave and end the phase.
   task automatic gapRun(input logic d);
      int k, pulses = 0, rdenAt = 0, endAt = 0, tail = 0;
      logic seen = 0, irqSeen = 0, gerSeen = 0, c2Seen = 0, sipSeen = 0;
      logic sopSeen = 0;
      bus(1'b1, REG_ADDRESS, 32'h0000_5542, rd);
      transfer_direction_bit <= d;
      device_address_match <= 1'b1;
      cmdAddrMatch <= 1'b1;
      repeat (300) @(posedge clock);
      track(300);
      track(20);
      repeat (700) @(posedge clock);
      check("position", 32'h1, sectorPosition);
      check("band", 32'h155, bandLatched);
      check("no match", 32'h0, search_match_flag);
      track(20);
      for (k = 0; k < 3000; k++)
      begin
         @(posedge clock);
         if (search_match_flag === 1'b1 && writeClockTrackIn && !wPrev)
            pulses++;
         if (read_enable_flag === 1'b1 && rdenAt == 0) rdenAt = pulses;
         if (search_match_flag === 1'b1) seen = 1'b1;
         else if (seen && endAt == 0) endAt = pulses;
         irqSeen |= (sectorFoundIrq === 1'b1);
         gerSeen |= (gap_end_ready === 1'b1);
         c2Seen |= (count2Decode === 1'b1);
         sipSeen |= (sector_increment_pulse === 1'b1);
         sopSeen |= (sector_or_index_pulse === 1'b1);
         buffer_connect_command <= (pulses == 5);
         if (endAt != 0 && ++tail == 5) break;
      end
      if (k == 3000) hang();
      check("rden clock", 32'h3, rdenAt);
      check("gap clocks", 32'hD, endAt);
      check("count2", 32'h1, c2Seen);
      check("found", 32'h1, irqSeen);
      check("gap end", 32'h1, gerSeen);
      check("connected", 32'h1, channel_connected_flag);
      check("error", 32'h0, error_flag);
      check("phase", d ? 32'h1 : 32'h2, {phase_bit_high, phase_bit_low});
      check("rden", d ? 32'h0 : 32'h1, read_enable_flag);
      // Thirteen gap clocks leave four full cycles and one modulo-3 step.
      bus(1'b0, REG_STATUS, 32'h0, rd);
      check("chr", 32'h4, rd[ST_CHR_LSB +: CHAR_W]);
      check("mod3", 32'h1, rd[ST_MOD3_LSB +: 2]);
      check("preamble", 32'h1, rd[ST_PREAMBLE]);
      check("increment", 32'h1, sipSeen);
      check("sector event", 32'h1, sopSeen);
      check("last counts", 32'h0, last_counts_decode);
      bus(1'b1, REG_ADDRESS, 32'h0, rd);
      @(posedge clock);
      check("refused", 32'h1, error_flag);
      preambleDone <= 1'b1;
      @(posedge clock);
      preambleDone <= 1'b0;
      device_address_match <= 1'b0;
      for (k = 0; k < 400 && channel_connected_flag !== 1'b0; k++)
         @(posedge clock);
      check("dropped", 32'h0, channel_connected_flag);
      phaseEnd <= 1'b1;
      @(posedge clock);
      phaseEnd <= 1'b0;
      repeat (3) @(posedge clock);
      check("standby", 32'h0, {phase_bit_high, phase_bit_low});
   endtask : gapRun

   // Reset is held for sixteen cycles, then the scenarios run in order.
   initial
   begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      regAccess();
      gapRun(1'b1);
      gapRun(1'b0);
      results();
   end
endmodule : disc_sector_search_gap_seq_tb
